/* File: bmd_core.sv */
// Base memory range: config register, decode, page policy, prefetch control
// Function
// - Reset clears the whole configuration register; range stays disabled.
// - Configuration register is one 32-bit word at offset zero.
// - Type 0 is EDO, 3 is SDRAM; 1 and 2 must not be used.
// - Delay bit adds one clock to the valid response.
// - Enable bit gates the whole base range.
// - Mux select picks modes 0-3; wide bit forces mode 4.
// - Keep-open bit holds row strobe after a cycle; EDO only.
// - Latency bit picks three clocks (0) or two clocks (1).
// - Mask bits 1 keep address bits 25:22 compared.
// - Row and half selects each cover half the decoded range.
// - Base field 27:22 matched against address, masked bits ignored.
// - Address bit 28 ignored in decode; range aliases 256 MB apart.
// - Bit 28 set with page mode: hit uses column-only, page stays open.
// - Bit 28 clear: hit or miss runs, page closes at end.
// - Page mode on: each read fetches two further words.
// - Sequential reads served from buffer three clocks sooner.
// - Other accesses keep buffer; base writes invalidate it.
// - Prefetch words follow the read size and alignment.
// - Posted writes are flushed before any read is serviced.
`timescale 1ns/10ps
module bmd_core #(
  parameter int WIDTH = 32,
  parameter int ROW_BITS = 11
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire bmd_pkg::bmd_req_type cpu_req,
  input wire logic write_buffer_empty,
  input wire logic [WIDTH-1:0] mem_rdata [2],
  output logic flush_request,
  output logic base_hit,
  output logic cpu_ext_valid,
  output logic from_prefetch,
  output logic [WIDTH-1:0] prefetch_data [2],
  output logic [28:0] fetch_addr,
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic base_row_select_n,
  output logic base_half_select_n,
  output logic [2:0] mux_mode,
  output logic [3:0] cas_latency
);
  import bmd_pkg::*;

  if (WIDTH < 1 || ROW_BITS < 1 || ROW_BITS > 20) begin : g_bad_param
    $error("bad width parameter");
  end

  // ************************************************************
  // Configuration register
  // ************************************************************
  logic [31:0] cfg_q;
  bmd_cfg_type cfg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= BMD_CFG_RESET;
    end else if (reg_write && reg_addr == BMD_CFG_OFFSET) begin
      cfg_q <= reg_wdata & BMD_CFG_WMASK;
    end
  end

  assign cfg.mem_type = cfg_q[BMD_TYPE_LSB +: 2];
  assign cfg.valid_delay = cfg_q[BMD_DELAY_BIT];
  assign cfg.enable = cfg_q[BMD_EN_BIT];
  assign cfg.mux_sel = cfg_q[BMD_MUX_LSB +: 2];
  assign cfg.page_keep_open = cfg_q[BMD_PAGE_BIT];
  assign cfg.column_latency_sel = cfg_q[BMD_COLUMN_LATENCY_SEL_BIT];
  assign cfg.wide_device_mux = cfg_q[BMD_WIDE_BIT];
  assign cfg.mask = cfg_q[BMD_MASK_LSB +: 4];
  assign cfg.region_base = cfg_q[BMD_BASE_LSB +: 6];

  // Page mode is honoured only with EDO; SDRAM with it set is a software fault
  logic page_mode;
  assign page_mode = cfg.page_keep_open && cfg.mem_type == BMD_TYPE_EDO;

  // ************************************************************
  // Mux mode and latency
  // ************************************************************
  always_comb begin
    if (cfg.wide_device_mux) begin
      mux_mode = BMD_MUX_WIDE;
    end else begin
      mux_mode = {1'b0, cfg.mux_sel};
    end
  end

  assign cas_latency = cfg.column_latency_sel ? BMD_CAS_SHORT : BMD_CAS_LONG;

  // ************************************************************
  // Address decode
  // ************************************************************
  logic [31:0] byte_addr;
  logic [5:0] cmp_mask;
  logic range_hit;
  logic alias_hi;

  assign byte_addr = {1'b0, cpu_req.word_addr, 2'b00};
  // Bits 27:26 are always compared; 25:22 per mask
  assign cmp_mask = {2'b11, cfg.mask};
  assign range_hit = ((byte_addr[27:22] ^ cfg.region_base) & cmp_mask) == 6'h00;
  // Bit 28 never enters the compare, so both aliases decode
  assign alias_hi = byte_addr[BMD_ALIAS_BIT];
  assign base_hit = cpu_req.valid && cfg.enable && range_hit;

  // Half select is the top decoded-away bit: the bit just below the lowest compared mask bit, or 25 when none compared
  logic half_bit;
  always_comb begin
    if (cfg.mask[0]) begin
      half_bit = byte_addr[21];
    end else if (cfg.mask[1]) begin
      half_bit = byte_addr[22];
    end else if (cfg.mask[2]) begin
      half_bit = byte_addr[23];
    end else if (cfg.mask[3]) begin
      half_bit = byte_addr[24];
    end else begin
      half_bit = byte_addr[25];
    end
  end

  // ************************************************************
  // Flush and access sequencing
  // ************************************************************
  typedef enum logic [1:0] {IDLE, FLUSH, ACCESS, DONE} bmd_state_type;
  bmd_state_type state_q;
  bmd_req_type req_q;
  logic half_q;
  logic [3:0] count_q;
  logic pf_hit;
  logic pf_load;
  logic done_d1_q;
  logic take;

  assign flush_request = state_q == FLUSH;
  // With the delayed answer the master still holds its request in IDLE; never take it twice
  assign take = base_hit && !(cfg.valid_delay && done_d1_q);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= IDLE;
      req_q <= '0;
      half_q <= 1'b0;
      count_q <= 4'h0;
    end else begin
      unique case (state_q)
        IDLE: begin
          if (take) begin
            req_q <= cpu_req;
            half_q <= half_bit;
            // Reads wait for the posted writes to drain first
            if (!cpu_req.write && !write_buffer_empty) begin
              state_q <= FLUSH;
            end else begin
              state_q <= ACCESS;
            end
            count_q <= (!cpu_req.write && pf_hit) ? BMD_READ_LAT - BMD_SEQ_SAVING
                       : BMD_READ_LAT;
          end
        end
        FLUSH: begin
          if (write_buffer_empty) begin
            state_q <= ACCESS;
          end
        end
        ACCESS: begin
          if (count_q <= 4'h1) begin
            state_q <= DONE;
          end else begin
            count_q <= count_q - 4'h1;
          end
        end
        DONE: begin
          state_q <= IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Valid response with optional delay
  // ************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_d1_q <= 1'b0;
    end else begin
      done_d1_q <= state_q == DONE;
    end
  end
  assign cpu_ext_valid = cfg.valid_delay ? done_d1_q : state_q == DONE;

  // ************************************************************
  // Strobes and open page tracking
  // ************************************************************
  logic page_open_q;
  logic [ROW_BITS-1:0] open_row_q;
  logic [ROW_BITS-1:0] req_row;
  logic page_match;
  logic row_on;
  logic col_on;

  assign req_row = req_q.word_addr[9 +: ROW_BITS];
  assign page_match = page_open_q && req_row == open_row_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      page_open_q <= 1'b0;
      open_row_q <= '0;
    end else if (!page_mode) begin
      page_open_q <= 1'b0;
    end else if (state_q == DONE) begin
      // Bit 28 set leaves the page open; clear closes it
      page_open_q <= req_q.word_addr[BMD_ALIAS_BIT - 2];
      open_row_q <= req_row;
    end
  end

  // Miss precharges: row strobe held off in the first access cycle
  assign row_on = (state_q == ACCESS && (page_match || count_q != BMD_READ_LAT))
                  || (page_open_q && state_q != ACCESS);
  assign col_on = state_q == ACCESS && count_q <= 4'h2;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      row_strobe_n <= 1'b1;
      column_strobe_n <= 1'b1;
      base_row_select_n <= 1'b1;
      base_half_select_n <= 1'b1;
    end else begin
      row_strobe_n <= !row_on;
      column_strobe_n <= !col_on;
      base_row_select_n <= !(state_q == ACCESS && !half_q);
      base_half_select_n <= !(state_q == ACCESS && half_q);
    end
  end

  // ************************************************************
  // Prefetch address generation
  // ************************************************************
  logic [28:0] next_word;
  always_comb begin
    unique case (req_q.words)
      2'h0: next_word = req_q.word_addr + 29'h1;
      2'h1: next_word = req_q.word_addr + 29'h2;
      2'h2, 2'h3: next_word = {req_q.word_addr[28:2], 2'b00} + 29'h4;
    endcase
  end

  // Even and odd one-word reads both fetch n+1 first; two-word reads fetch n+2, larger ones the next aligned four
  assign fetch_addr = next_word;

  assign pf_load = page_mode && state_q == DONE && !req_q.write;
  assign from_prefetch = state_q == ACCESS && !req_q.write && count_q != 4'h0
                         && req_q.valid && pf_hit;

  bmd_prefetch #(
    .WIDTH(WIDTH),
    .DEPTH(2)
  ) bmd_prefetch_i (
    .clk(clk),
    .reset_n(reset_n),
    .load(pf_load),
    .next_addr(fetch_addr),
    .load_data(mem_rdata),
    .invalidate(base_hit && cpu_req.write && state_q == IDLE),
    .lookup_addr(state_q == IDLE ? cpu_req.word_addr : req_q.word_addr),
    .hit(pf_hit),
    .data_q(prefetch_data)
  );

  // ************************************************************
  // Register read port
  // ************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      unique case (reg_addr)
        BMD_CFG_OFFSET: reg_rdata <= cfg_q;
        BMD_STAT_OFFSET: reg_rdata <= {28'h000_0000, page_open_q, pf_hit,
                                       state_q != IDLE, flush_request};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  reset_clear_a: assert property (@(posedge clk) $rose(reset_n) |-> cfg_q == 32'h0)
    else $error("config not cleared by reset");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg_q & ~BMD_CFG_WMASK) == 32'h0)
    else $error("reserved bit set");
  disabled_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!cfg.enable && state_q == IDLE) |=> state_q == IDLE)
    else $error("disabled range responded");
  valid_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == DONE && cfg.valid_delay && $stable(cfg_q)) |=> cpu_ext_valid)
    else $error("delayed valid missing");
  no_retake_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == IDLE && cfg.valid_delay && done_d1_q) |=> state_q == IDLE)
    else $error("request taken twice");
  page_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == DONE && page_mode && req_q.word_addr[BMD_ALIAS_BIT - 2]) |=> page_open_q)
    else $error("page not held open");
  page_close_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == DONE && !req_q.word_addr[BMD_ALIAS_BIT - 2]) |=> !page_open_q)
    else $error("page not closed");
  wide_mux_a: assert property (@(posedge clk) disable iff (!reset_n)
    cfg.wide_device_mux |-> mux_mode == 3'h4)
    else $error("wide mux not mode 4");
  latency_a: assert property (@(posedge clk) disable iff (!reset_n)
    cas_latency == (cfg.column_latency_sel ? 4'h2 : 4'h3))
    else $error("latency wrong");
  flush_first_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == FLUSH && !write_buffer_empty) |=> state_q == FLUSH)
    else $error("read before flush");
  write_inval_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == IDLE && base_hit && cpu_req.write) |=> !pf_hit || !req_q.valid)
    else $error("write kept prefetch");
  alias_hit_a: assert property (@(posedge clk) disable iff (!reset_n)
    (base_hit && alias_hi) |-> range_hit)
    else $error("alias decode");
  seq_read_c: cover property (@(posedge clk) disable iff (!reset_n)
    state_q == IDLE && base_hit && !cpu_req.write && pf_hit);
  flush_c: cover property (@(posedge clk) disable iff (!reset_n) state_q == FLUSH);
  page_open_c: cover property (@(posedge clk) disable iff (!reset_n) $rose(page_open_q));
  delay_valid_c: cover property (@(posedge clk) disable iff (!reset_n)
    cfg.valid_delay && done_d1_q);
  page_hit_c: cover property (@(posedge clk) disable iff (!reset_n)
    state_q == ACCESS && page_match);

endmodule

/* File: bmd_pkg.sv */
// Package: base memory decode register map, fields and types
package bmd_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] BMD_CFG_OFFSET = 8'h00;
  localparam logic [7:0] BMD_STAT_OFFSET = 8'h04;
  localparam logic [31:0] BMD_CFG_RESET = 32'h0000_0000;
  // Writable bits; everything else reads as zero
  localparam logic [31:0] BMD_CFG_WMASK = 32'h0fc3_d1bf;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BMD_TYPE_LSB = 0;
  localparam int BMD_DELAY_BIT = 2;
  localparam int BMD_EN_BIT = 3;
  localparam int BMD_MUX_LSB = 4;
  localparam int BMD_PAGE_BIT = 7;
  localparam int BMD_COLUMN_LATENCY_SEL_BIT = 8;
  localparam int BMD_WIDE_BIT = 12;
  localparam int BMD_MASK_LSB = 14;
  localparam int BMD_BASE_LSB = 22;
  localparam int BMD_ALIAS_BIT = 28;

  localparam logic [1:0] BMD_TYPE_EDO = 2'h0;
  localparam logic [1:0] BMD_TYPE_SDRAM = 2'h3;
  localparam logic [2:0] BMD_MUX_WIDE = 3'h4;

  // ************************************************************
  // Timing counts
  // ************************************************************
  localparam logic [3:0] BMD_SEQ_SAVING = 4'h3;
  localparam logic [3:0] BMD_READ_LAT = 4'h6;
  localparam logic [3:0] BMD_CAS_LONG = 4'h3;
  localparam logic [3:0] BMD_CAS_SHORT = 4'h2;

  typedef struct packed {
    logic [1:0] mem_type;
    logic valid_delay;
    logic enable;
    logic [1:0] mux_sel;
    logic page_keep_open;
    logic column_latency_sel;
    logic wide_device_mux;
    logic [3:0] mask;
    logic [5:0] region_base;
  } bmd_cfg_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] words;
    logic [28:0] word_addr;
  } bmd_req_type;

endpackage

/* File: bmd_prefetch.sv */
// Two-word read prefetch buffer with sequential-hit detect
`timescale 1ns/10ps
module bmd_prefetch #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [28:0] next_addr,
  input wire logic [WIDTH-1:0] load_data [DEPTH],
  input wire logic invalidate,
  input wire logic [28:0] lookup_addr,
  output logic hit,
  output logic [WIDTH-1:0] data_q [DEPTH]
);
  import bmd_pkg::*;

  if (DEPTH != 2) begin : g_bad_depth
    $error("prefetch depth must be 2");
  end

  logic valid_q;
  logic [28:0] next_addr_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      valid_q <= 1'b0;
      next_addr_q <= '0;
    end else if (invalidate) begin
      valid_q <= 1'b0;
    end else if (load) begin
      valid_q <= 1'b1;
      next_addr_q <= next_addr;
    end
  end

  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          data_q[i] <= '0;
        end else if (load && !invalidate) begin
          data_q[i] <= load_data[i];
        end
      end
    end
  endgenerate

  // Hit is exact: the read must start at the first buffered word
  assign hit = valid_q && (lookup_addr == next_addr_q);

endmodule

/* File: bmd_mem_model.sv */
// Memory device model: returns a pattern word for each fetched word address
`timescale 1ns/10ps
module bmd_mem_model (
  input wire logic clk,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic [28:0] fetch_addr,
  output logic [31:0] mem_rdata [2]
);
  // ************************************************************
  // Read data
  // ************************************************************
  // Each word carries its own address, so a wrong fetch address shows up as wrong data
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      mem_rdata[i] = {3'h0, fetch_addr + 29'(i)} ^ 32'ha5c3_0000;
      // Outside a strobed column access the bus shows garbage, so a mistimed load fails
      if (row_strobe_n || column_strobe_n) mem_rdata[i] = ~mem_rdata[i];
    end
  end
endmodule

/* File: bmd_core_bench.sv */
// Self-checking testbench for the base memory decode block
`timescale 1ns/10ps
module bmd_core_bench;
  import bmd_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  bmd_req_type cpu_req = '0;
  logic wb_empty = 1'b1;
  logic [31:0] mem_rdata [2];
  logic [31:0] pf_data [2];
  logic flush_request, base_hit, cpu_ext_valid, from_prefetch;
  logic row_n, col_n, brs_n, bhs_n;
  logic [28:0] fetch_addr;
  logic [2:0] mux_mode;
  logic [3:0] cas_latency;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  logic hit, saw_r, saw_h, saw_pf, saw_c;

  always #12.5 clk = ~clk;

  bmd_core bmd_core_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .cpu_req(cpu_req), .write_buffer_empty(wb_empty), .mem_rdata(mem_rdata),
    .flush_request(flush_request), .base_hit(base_hit), .cpu_ext_valid(cpu_ext_valid),
    .from_prefetch(from_prefetch), .prefetch_data(pf_data), .fetch_addr(fetch_addr),
    .row_strobe_n(row_n), .column_strobe_n(col_n), .base_row_select_n(brs_n),
    .base_half_select_n(bhs_n), .mux_mode(mux_mode), .cas_latency(cas_latency));

  bmd_mem_model bmd_mem_model_i (.clk(clk), .row_strobe_n(row_n), .column_strobe_n(col_n),
    .fetch_addr(fetch_addr), .mem_rdata(mem_rdata));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  // Holds the request until the answer pulse; n counts cycles to it
  task automatic access(input logic w, input logic [1:0] k, input logic [28:0] a, output int n);
    @(posedge clk);
    cpu_req <= {1'b1, w, k, a};
    saw_r = 1'b0;
    saw_h = 1'b0;
    saw_pf = 1'b0;
    saw_c = 1'b0;
    n = 0;
    @(negedge clk);
    hit = base_hit;
    while (hit === 1'b1 && cpu_ext_valid !== 1'b1 && n < 60) begin
      saw_r = saw_r | (brs_n === 1'b0);
      saw_h = saw_h | (bhs_n === 1'b0);
      saw_pf = saw_pf | (from_prefetch === 1'b1);
      saw_c = saw_c | (col_n === 1'b0);
      @(negedge clk);
      n++;
    end
    if (n == 60) chk(32'(n), 32'h0);
    @(posedge clk);
    cpu_req.valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  function automatic logic exp_hit(input logic [31:0] c, input logic [28:0] a);
    return c[3] && (((a[25:20] ^ c[27:22]) & {2'b11, c[17:14]}) == 6'h00);
  endfunction

  function automatic logic [28:0] exp_pf(input logic [1:0] k, input logic [28:0] n);
    if (k == 2'h0) return n + 29'h1;
    if (k == 2'h1) return n + 29'h2;
    return {n[28:2], 2'h0} + 29'h4;
  endfunction

  function automatic logic [31:0] val(input logic [28:0] a);
    return {3'h0, a} ^ 32'ha5c3_0000;
  endfunction

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [31:0] d, v, cfg;
    logic [28:0] a, x, y;
    int n0, n1, k;
    void'($urandom(32'hbe1ca194));
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    reg_rd(8'h00, d);
    chk(d, 32'h0);
    reg_rd(8'h10, d);
    chk(d, 32'h0);
    for (int i = 0; i < 12; i++) begin
      v = $urandom;
      v[1:0] = v[0] ? 2'h3 : 2'h0;
      v[3] = 1'b0;
      v[17:14] = 4'hf << $urandom_range(4);
      if (v[1:0] == 2'h3) begin
        v[7] = 1'b0;
        v[5:4] = 2'h3;
      end
      reg_wr(8'h00, v);
      reg_wr(8'h24, ~v);
      reg_rd(8'h00, d);
      chk(d, v & 32'h0fc3_d1bf);
      chk(32'(mux_mode), v[12] ? 32'h4 : 32'(v[5:4]));
      chk(32'(cas_latency), v[8] ? 32'h2 : 32'h3);
    end
    for (int i = 0; i < 16; i++) begin
      k = $urandom_range(4);
      cfg = 32'h0;
      cfg[27:22] = 6'($urandom);
      cfg[17:14] = 4'hf << k;
      cfg[3] = (i % 4 != 3);
      a = 29'($urandom);
      if (i % 2 == 1) a[25:20] = cfg[27:22];
      reg_wr(8'h00, cfg);
      access(1'b0, 2'h0, a, n0);
      chk(hit, exp_hit(cfg, a));
      if (hit === 1'b1) chk({saw_r, saw_h}, a[19 + k] ? 2'b01 : 2'b10);
      if (hit === 1'b1) chk(saw_c, 1'b1);
    end
    cfg = (32'h5 << 22) | (32'hf << 14) | 32'h8;
    reg_wr(8'h00, cfg);
    access(1'b1, 2'h0, 29'h050_0000, n0);
    reg_wr(8'h00, cfg | 32'h4);
    access(1'b1, 2'h0, 29'h050_0000, n1);
    chk(n1, n0 + 1);
    reg_wr(8'h00, cfg);
    wb_empty <= 1'b0;
    fork
      access(1'b0, 2'h0, 29'h050_0010, n1);
      begin
        repeat (6) @(negedge clk);
        chk(flush_request, 1'b1);
        @(posedge clk);
        wb_empty <= 1'b1;
      end
    join
    chk(n1 >= n0 + 3, 1'b1);
    cfg = cfg | 32'h80;
    reg_wr(8'h00, cfg);
    a = 29'h450_0000;
    access(1'b0, 2'h0, a, n0);
    for (int c = 0; c < 4; c++) begin
      k = (c < 2) ? 0 : c - 1;
      x = a + 29'(32 + 16 * c + ((c == 1) ? 1 : (c == 3) ? 2 : 0));
      access(1'b0, 2'(k), x, n0);
      y = exp_pf(2'(k), x);
      chk(pf_data[0], val(y));
      if (c != 0) chk(pf_data[1], val(y + 29'h1));
      if (c != 1 && c != 3) begin
        access(1'b0, 2'(k), x + 29'(1 << k), n1);
        chk(n1 + 3, n0);
        chk(saw_pf, 1'b1);
      end
    end
    x = a + 29'd200;
    access(1'b0, 2'h0, x, n0);
    access(1'b0, 2'h0, 29'h0, n1);
    chk(hit, 1'b0);
    access(1'b0, 2'h0, x + 29'h1, n1);
    chk(n1 + 3, n0);
    access(1'b1, 2'h0, a + 29'd300, n1);
    access(1'b0, 2'h0, x + 29'h2, n1);
    chk(n1, n0);
    chk(saw_pf, 1'b0);
    @(negedge clk);
    chk(row_n, 1'b0);
    reg_rd(8'h04, d);
    chk(d, 32'h8);
    access(1'b0, 2'h0, 29'h050_0040, n1);
    @(negedge clk);
    chk(row_n, 1'b1);
    final_report();
  end
endmodule
